// *** include/idq_pkg.sv ***
// idq_pkg: shared constants, types and decode helpers
package idq_pkg;
    localparam int IDQ_NCH  = 4;  // counter input channels
    localparam int IDQ_NENC = 2;  // encoder slots (A even, B odd)
    localparam int IDQ_CW   = 22; // debounce counter width
    localparam int IDQ_ZCH  = 2;  // channel that carries index

    // clock period in ns (100 MHz)
    localparam int unsigned IDQ_CLK_NS = 10;

    // debounce settings, in ns
    localparam int unsigned IDQ_DB_SHORTEST_NS = 500;
    localparam int unsigned IDQ_DB_LONGEST_NS  = 25_500_000;
    localparam int unsigned IDQ_DB_NS [16] = '{
        IDQ_DB_SHORTEST_NS, 1_000, 2_000, 5_000,
        10_000, 20_000, 50_000, 100_000,
        200_000, 500_000, 1_000_000, 2_000_000,
        5_000_000, 10_000_000, 20_000_000, IDQ_DB_LONGEST_NS
    };
    // least times round up to whole cycles
    localparam int unsigned IDQ_DB_CYC_LONGEST =
        (IDQ_DB_LONGEST_NS + IDQ_CLK_NS - 1) / IDQ_CLK_NS;

    // start values for counts and timer, count step and count ceiling
    localparam logic [31:0]       IDQ_CNT_RST = 32'h0000_0000;
    localparam logic [IDQ_CW-1:0] IDQ_TMR_RST = 22'h00_0000;
    localparam logic [31:0]       IDQ_ONE     = 32'h0000_0001;
    localparam logic [31:0]       IDQ_CNT_MAX = 32'hFFFF_FFFF;

    // filter mode; 2'b11 behaves as bypass
    typedef enum logic [1:0] {
        IDQ_DB_AFTER  = 2'b00,
        IDQ_DB_BEFORE = 2'b01,
        IDQ_DB_BYPASS = 2'b10
    } idq_db_mode_t;

    // edge multiplication; 2'b11 behaves as four-times
    typedef enum logic [1:0] {
        IDQ_X1 = 2'b00,
        IDQ_X2 = 2'b01,
        IDQ_X4 = 2'b10
    } idq_mult_t;

    // debounce time select to cycle count, capped for short sims
    function automatic logic [IDQ_CW-1:0] idq_db_cycles(
        input logic [3:0]        sel,
        input logic [IDQ_CW-1:0] cap
    );
        logic [IDQ_CW-1:0] c;
        c = IDQ_CW'((IDQ_DB_NS[sel] + IDQ_CLK_NS - 1) / IDQ_CLK_NS);
        return (c > cap) ? cap : c;
    endfunction

    // quadrature step: {count, up}
    function automatic logic [1:0] idq_quad_step(
        input logic       a0,
        input logic       a1,
        input logic       b0,
        input logic       b1,
        input logic [1:0] m
    );
        logic ea;
        logic eb;
        logic [1:0] r;
        ea = a0 ^ a1;
        eb = b0 ^ b1;
        r  = 2'b00;
        case (m)
            IDQ_X1: r = {a1 & ~a0 & ~eb, a1 ^ b1};
            IDQ_X2: r = {ea & ~eb, a1 ^ b1};
            default: begin
                // a and b moving together is illegal: skip it
                if (ea && !eb) begin
                    r = {1'b1, a1 ^ b1};
                end else if (eb && !ea) begin
                    r = {1'b1, ~(a1 ^ b1)};
                end
            end
        endcase
        return r;
    endfunction
endpackage

// *** core/idq_sync.sv ***
// idq_sync: two-flop synchroniser for the raw inputs
`timescale 1ns/1ps
`default_nettype none
module idq_sync
    import idq_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // first stage feeds only the second
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } idq_sync_st_t;

    idq_sync_st_t st;      // registered state
    idq_sync_st_t next_st; // next state

    // shift the pins through two stages
    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // synchronous reset to zero
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule
`default_nettype wire

// *** core/idq_debounce.sv ***
// idq_debounce: one channel of inversion and debounce filter
`timescale 1ns/1ps
`default_nettype none
module idq_debounce
    import idq_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              raw,
    input  wire logic              invert,
    input  wire logic [1:0]        mode,
    input  wire logic [3:0]        tsel,
    input  wire logic [IDQ_CW-1:0] cap,
    output logic                   filt
);
    typedef struct packed {
        logic              prev; // level seen last cycle
        logic              out;  // filtered level
        logic [IDQ_CW-1:0] cnt;  // cycles prev has held
    } idq_db_st_t;

    idq_db_st_t        st;      // registered state
    idq_db_st_t        next_st; // next state
    logic              lvl;     // input after inversion
    logic [IDQ_CW-1:0] target;  // selected debounce count
    logic              stable;  // level held for debounce time
    logic              edge_in; // level differs from last cycle

    assign lvl     = raw ^ invert;
    assign target  = idq_db_cycles(tsel, cap);
    assign stable  = (st.cnt >= target); // a lowered setting counts as met at once
    assign edge_in = (lvl != st.prev);

    // stability timer and output decision
    always_comb begin
        next_st      = st;
        next_st.prev = lvl;
        // any raw change restarts the timer
        if (edge_in) begin
            next_st.cnt = IDQ_TMR_RST;
        end else if (!stable) begin
            next_st.cnt = st.cnt + 22'h00_0001;
        end
        case (mode)
            IDQ_DB_AFTER: begin
                // move only after the new level settled
                if (stable && st.out != st.prev) begin
                    next_st.out = st.prev;
                end
            end
            IDQ_DB_BEFORE: begin
                // pass an edge at once if quiet before it
                if (edge_in && stable) begin
                    next_st.out = lvl;
                end else if (stable && st.out != st.prev) begin
                    // burst ended on the other level: settle to it
                    next_st.out = st.prev;
                end
            end
            default: begin
                next_st.out = lvl;
            end
        endcase
    end

    // synchronous reset, output starts low
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign filt = st.out;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_after_settle: assert property (
        ($past(mode) == IDQ_DB_AFTER) && $changed(st.out)
        |-> $past(stable) && (st.out == $past(st.prev)))
        else $error("settle mode moved before stable");
    a_before_pass: assert property (
        (mode == IDQ_DB_BEFORE) && edge_in && stable
        |=> (st.out == $past(lvl)))
        else $error("accepted edge not passed at once");
    a_before_hold: assert property (
        (mode == IDQ_DB_BEFORE) && !stable |=> $stable(st.out))
        else $error("hold mode changed while unstable");
    a_bypass_copy: assert property (
        (mode == IDQ_DB_BYPASS) |=> (st.out == $past(lvl)))
        else $error("bypass did not copy input");
    a_timer_restart: assert property (
        edge_in |=> (st.cnt == IDQ_TMR_RST))
        else $error("timer not restarted on change");
endmodule
`default_nettype wire

// *** core/idq_top.sv ***
// idq_top: counter input front end with quadrature decoder
`timescale 1ns/1ps
`default_nettype none
module idq_top
    import idq_pkg::*;
#(
    // longest debounce count; lower it to shorten simulation
    parameter int unsigned deb_cycle_cap = IDQ_DB_CYC_LONGEST
) (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic [IDQ_NCH-1:0]       ctr_in,
    input  wire logic [IDQ_NCH-1:0]       ctr_invert,
    input  wire logic [2*IDQ_NCH-1:0]     db_mode,
    input  wire logic [4*IDQ_NCH-1:0]     db_time,
    input  wire logic                     acq_start,
    input  wire logic                     index_en,
    input  wire logic [2*IDQ_NENC-1:0]    enc_mult,
    input  wire logic [IDQ_NENC-1:0]      enc_wide,
    output logic      [IDQ_NCH-1:0]       filt_out,
    output logic      [IDQ_NENC-1:0][31:0] enc_pos,
    output logic      [IDQ_NENC-1:0]      enc_dir,
    output logic      [IDQ_NENC-1:0][31:0] enc_period,
    output logic      [31:0]              enc_revs
);
    // cap cut to the timer width on purpose
    localparam logic [IDQ_CW-1:0] CAP = IDQ_CW'(deb_cycle_cap);

    // all decoder state in one record
    typedef struct packed {
        logic [IDQ_NENC-1:0]       a_d;     // last phase a
        logic [IDQ_NENC-1:0]       b_d;     // last phase b
        logic                      z_d;     // last index
        logic [IDQ_NENC-1:0][31:0] pos;     // position count
        logic [IDQ_NENC-1:0][31:0] per_cnt; // cycles since a rise
        logic [IDQ_NENC-1:0][31:0] period;  // last a period
        logic [IDQ_NENC-1:0]       dir;     // 1 = forward
        logic [31:0]               revs;    // index crossings
    } idq_top_st_t;

    idq_top_st_t         st;       // registered state
    idq_top_st_t         next_st;  // next state
    logic [IDQ_NCH-1:0]  raw_sync; // inputs in clock domain
    logic [IDQ_NCH-1:0]  filt;     // filtered levels
    logic [IDQ_NENC-1:0] enc_on;   // encoder slot usable
    logic [IDQ_NENC-1:0] step_cnt; // count this cycle
    logic [IDQ_NENC-1:0] step_up;  // count direction
    logic [IDQ_NENC-1:0] a_rise;   // phase a rising
    logic [IDQ_NENC-1:0] a_fall;   // phase a falling
    logic                z_rise;   // index marker edge

    // pins cross into mclk before any decode; two stages plus
    // the filter flop still leave margin at 20 MHz input
    idq_sync #(
        .W(IDQ_NCH)
    ) u_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .d      (ctr_in),
        .q      (raw_sync)
    );

    // one filter per input channel
    genvar g;
    generate
        for (g = 0; g < IDQ_NCH; g++) begin : g_db
            idq_debounce u_db (
                .mclk   (mclk),
                .resetn (resetn),
                .raw    (raw_sync[g]),
                .invert (ctr_invert[g]),
                .mode   (db_mode[2*g +: 2]),
                .tsel   (db_time[4*g +: 4]),
                .cap    (CAP),
                .filt   (filt[g])
            );
        end
    endgenerate

    // index steals channel 2, so slot 1 is off while it is used
    assign enc_on = {~index_en, 1'b1};
    assign z_rise = index_en & filt[IDQ_ZCH] & ~st.z_d;

    // edge helpers per encoder slot
    always_comb begin
        for (int e = 0; e < IDQ_NENC; e++) begin
            {step_cnt[e], step_up[e]} = idq_quad_step(
                st.a_d[e], filt[2*e],
                st.b_d[e], filt[2*e+1],
                enc_mult[2*e +: 2]);
            a_rise[e] = filt[2*e] & ~st.a_d[e];
            a_fall[e] = ~filt[2*e] & st.a_d[e];
        end
    end

    // counters, direction, period and revolutions
    always_comb begin
        next_st     = st;
        next_st.z_d = filt[IDQ_ZCH];
        for (int e = 0; e < IDQ_NENC; e++) begin
            next_st.a_d[e] = filt[2*e];
            next_st.b_d[e] = filt[2*e+1];
            // up when a leads b, down when it lags
            if (step_cnt[e]) begin
                if (step_up[e]) begin
                    next_st.pos[e] = st.pos[e] + IDQ_ONE;
                end else begin
                    next_st.pos[e] = st.pos[e] - IDQ_ONE;
                end
                next_st.dir[e] = step_up[e];
            end
            // velocity as cycles between a rises
            if (a_rise[e]) begin
                next_st.period[e]  = st.per_cnt[e] + IDQ_ONE;
                next_st.per_cnt[e] = IDQ_CNT_RST;
            end else if (st.per_cnt[e] != IDQ_CNT_MAX) begin
                // saturate; the next a rise then wraps the period to zero
                next_st.per_cnt[e] = st.per_cnt[e] + IDQ_ONE;
            end
            // narrow counter rolls over at 16 bits
            if (!enc_wide[e]) begin
                next_st.pos[e][31:16] = 16'h0000;
            end
            // unusable slot holds everything at zero
            if (!enc_on[e]) begin
                next_st.pos[e]     = IDQ_CNT_RST;
                next_st.per_cnt[e] = IDQ_CNT_RST;
                next_st.period[e]  = IDQ_CNT_RST;
                next_st.dir[e]     = 1'b0;
            end
        end
        // index wins over a count in the same cycle
        if (z_rise) begin
            next_st.pos[0] = IDQ_CNT_RST;
            next_st.revs   = st.revs + IDQ_ONE;
        end
        // a new acquisition starts every count from zero
        if (acq_start) begin
            for (int e = 0; e < IDQ_NENC; e++) begin
                next_st.pos[e]     = IDQ_CNT_RST;
                next_st.per_cnt[e] = IDQ_CNT_RST;
                next_st.period[e]  = IDQ_CNT_RST;
            end
            next_st.revs = IDQ_CNT_RST;
        end
    end

    // synchronous reset clears all counts
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flops
    assign filt_out   = filt;
    assign enc_pos    = st.pos;
    assign enc_dir    = st.dir;
    assign enc_period = st.period;
    assign enc_revs   = st.revs;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // plain step with nothing overriding it
    logic quiet0;
    assign quiet0 = !acq_start && !z_rise && enc_wide[0];

    a_dir_up: assert property (
        step_cnt[0] && step_up[0] && quiet0
        |=> enc_pos[0] == $past(enc_pos[0]) + IDQ_ONE)
        else $error("forward step did not add one");
    a_dir_down: assert property (
        step_cnt[0] && !step_up[0] && quiet0
        |=> enc_pos[0] == $past(enc_pos[0]) - IDQ_ONE)
        else $error("reverse step did not subtract one");
    a_x1_fall: assert property (
        (enc_mult[1:0] == IDQ_X1) && a_fall[0] && quiet0
        |=> $stable(enc_pos[0]))
        else $error("one-times counted a falling edge");
    a_x4_b_edge: assert property (
        (enc_mult[1:0] == IDQ_X4) && $changed(filt[1])
        && !$changed(filt[0]) && quiet0
        |-> ##1 $changed(enc_pos[0]))
        else $error("four-times missed a b edge");
    a_index_zero: assert property (
        z_rise && !acq_start |=> (enc_pos[0] == IDQ_CNT_RST)
        && (enc_revs == $past(enc_revs) + IDQ_ONE))
        else $error("index did not zero position");
    a_width_16: assert property (
        !enc_wide[0] |=> (enc_pos[0][31:16] == 16'h0000))
        else $error("narrow counter upper half not zero");
    a_enc1_off: assert property (
        index_en |=> (enc_pos[1] == IDQ_CNT_RST))
        else $error("second encoder counted with index on");
    a_acq_clear: assert property (
        acq_start |=> (enc_pos == '0) && (enc_revs == IDQ_CNT_RST))
        else $error("acquisition start left counts");

    // direction flag follows the last counted step
    a_dir_flag: assert property (
        step_cnt[0] |=> (enc_dir[0] == $past(step_up[0])))
        else $error("direction flag missed a step");

    // direction is kept while the shaft rests
    a_dir_hold: assert property (
        !step_cnt[0] |=> $stable(enc_dir[0]))
        else $error("direction moved without a step");

    // one-times counts every a rise while b holds
    a_x1_rise: assert property (
        (enc_mult[1:0] == IDQ_X1) && a_rise[0]
        && !$changed(filt[1]) && quiet0
        |=> $changed(enc_pos[0]))
        else $error("one-times missed an a rise");

    // two-times counts a alone, both ways
    a_x2_a_edge: assert property (
        (enc_mult[1:0] == IDQ_X2) && $changed(filt[0])
        && !$changed(filt[1]) && quiet0
        |=> $changed(enc_pos[0]))
        else $error("two-times missed an a edge");

    // two-times ignores b on its own
    a_x2_b_skip: assert property (
        (enc_mult[1:0] == IDQ_X2) && $changed(filt[1])
        && !$changed(filt[0]) && quiet0
        |=> $stable(enc_pos[0]))
        else $error("two-times counted a b edge");

    // four-times counts a edges as well as b edges
    a_x4_a_edge: assert property (
        (enc_mult[1:0] == IDQ_X4) && $changed(filt[0])
        && !$changed(filt[1]) && quiet0
        |=> $changed(enc_pos[0]))
        else $error("four-times missed an a edge");

    // no step, no index, no start: position holds
    a_pos_idle: assert property (
        !step_cnt[0] && quiet0 |=> $stable(enc_pos[0]))
        else $error("position moved without a step");

    // period only moves on a rise of a or a start
    a_period_hold: assert property (
        !a_rise[0] && !acq_start |=> $stable(enc_period[0]))
        else $error("period moved between a rises");

    // turn count only moves on an index mark or a start
    a_revs_hold: assert property (
        !z_rise && !acq_start |=> $stable(enc_revs))
        else $error("turn count moved without index");

    // low half of a narrow counter wraps through zero
    a_narrow_wrap: assert property (
        !enc_wide[0] && step_cnt[0] && !step_up[0]
        && !z_rise && !acq_start
        |=> (enc_pos[0][15:0] == $past(enc_pos[0][15:0]) - 16'h0001))
        else $error("narrow counter did not wrap");

    // disabled slot keeps direction and period at zero
    a_enc1_idle: assert property (
        index_en |=> !enc_dir[1] && (enc_period[1] == IDQ_CNT_RST))
        else $error("second encoder active with index on");

    // main scenarios worth seeing at least once
    c_reverse: cover property (step_cnt[0] && !step_up[0]);
    c_index: cover property (z_rise ##[1:50] step_cnt[0]);
    c_two_enc: cover property (!index_en && step_cnt[1]);
    c_x1_rise: cover property ((enc_mult[1:0] == IDQ_X1) && a_rise[0]);
    c_narrow: cover property (!enc_wide[0] && step_cnt[0]);
endmodule
`default_nettype wire

// *** testbench/idq_enc_model.sv ***
// idq_enc_model: quadrature encoder with index mark, far-side partner
`timescale 1ns/1ps
`default_nettype none
module idq_enc_model (
    input  wire logic mclk,
    output logic      a,
    output logic      b,
    output logic      z
);
    logic [1:0] ph; // quarter-cycle phase of the shaft

    // shaft at rest, all lines low
    initial begin
        ph = 2'h0;
        a  = 1'b0;
        b  = 1'b0;
        z  = 1'b0;
    end

    // walk n quarter steps; gap >= 1 keeps a and b edges in separate cycles
    task automatic move(input int n, input logic up, input int gap);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            ph = up ? ph + 2'h1 : ph - 2'h1;
            // a leads b going up: 00, 10, 11, 01; 90 degrees apart
            a = ph[1] ^ ph[0];
            b = ph[1];
            repeat (gap - 1) @(negedge mclk);
        end
    endtask

    // one index mark, w cycles wide, once per turn
    task automatic mark(input int w);
        @(negedge mclk);
        z = 1'b1;
        repeat (w) @(negedge mclk);
        z = 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_input_debounce_quadrature_decoder.sv ***
// tb_input_debounce_quadrature_decoder: self-checking bench for idq_top
`timescale 1ns/1ps
`default_nettype none
module tb_input_debounce_quadrature_decoder;
    import idq_pkg::*;
    localparam int unsigned CAP = 200; // longest debounce cut to 2 us

    logic             mclk;       // 100 MHz clock
    logic             resetn;     // sync reset, low active
    logic             pin3;       // lone debounce test pin
    logic             acq_start;  // acquisition start pulse
    logic             index_en;   // channel 2 as index
    logic [3:0]       ctr_invert; // per channel inversion
    logic [7:0]       db_mode;    // filter modes
    logic [15:0]      db_time;    // debounce selects
    logic [3:0]       enc_mult;   // edge multiplication
    logic [1:0]       enc_wide;   // 32-bit counting
    logic [3:0]       filt_out;
    logic [1:0][31:0] enc_pos;
    logic [1:0][31:0] enc_period;
    logic [1:0]       enc_dir;
    logic [31:0]      enc_revs;
    logic             a;          // encoder phase a
    logic             b;          // encoder phase b
    logic             z;          // encoder index
    int               err_total;
    int               num_checks;

    idq_top #(.deb_cycle_cap(CAP)) idq_top_inst (
        .mclk(mclk), .resetn(resetn), .ctr_in({pin3, z, b, a}), .ctr_invert(ctr_invert),
        .db_mode(db_mode), .db_time(db_time), .acq_start(acq_start), .index_en(index_en),
        .enc_mult(enc_mult), .enc_wide(enc_wide), .filt_out(filt_out), .enc_pos(enc_pos),
        .enc_dir(enc_dir), .enc_period(enc_period), .enc_revs(enc_revs)
    );

    idq_enc_model idq_enc_model_inst (.mclk(mclk), .a(a), .b(b), .z(z));

    // free-running clock
    always #5 mclk = ~mclk;

    // compare a count or word
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a single level
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // let n falling edges pass
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // set pin3 and count rising edges until its filtered level moves
    task automatic lat(input logic v, input logic [31:0] exp);
        logic o;
        int   n;
        o    = filt_out[3];
        pin3 = v;
        n    = 0;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (filt_out[3] === o && n < 1000); // bounded: a dead filter must not hang
        chk32(32'(n), exp);
        @(negedge mclk);
    endtask

    // one-cycle acquisition start
    task automatic acq;
        @(negedge mclk);
        acq_start = 1'b1;
        @(negedge mclk);
        acq_start = 1'b0;
    endtask

    // verdict, printed once from here only
    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // hang guard, about ten times the expected run
    initial begin
        #1_000_000;
        err_total++;
        complete_run;
    end

    // main sequence
    initial begin
        int unsigned t;
        mclk       = 1'b0;
        resetn     = 1'b0;
        pin3       = 1'b0;
        acq_start  = 1'b0;
        index_en   = 1'b0;
        ctr_invert = 4'h0;
        db_mode    = 8'h2A; // ch0..2 bypass, ch3 settle-then-pass
        db_time    = 16'h0000;
        enc_mult   = 4'h0;
        enc_wide   = 2'h3;
        err_total  = 0;
        num_checks = 0;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        @(posedge mclk);
        #1;
        chk32({28'h000_0000, filt_out}, 32'h0000_0000);
        chk32(enc_pos[0], 32'h0000_0000);
        @(negedge mclk);

        // settle mode at every time select; rising and falling alike
        for (int s = 0; s < 16; s++) begin
            t = (IDQ_DB_NS[s] + IDQ_CLK_NS - 1) / IDQ_CLK_NS;
            if (t > CAP) begin
                t = CAP;
            end
            db_time[15:12] = 4'(s);
            cyc(2);
            lat(1'b1, t + 4);
            cyc(2);
            lat(1'b0, t + 4);
        end

        // disturbance shorter than the 50-cycle window is dropped whole
        db_time[15:12] = 4'h0;
        pin3 = 1'b1;
        cyc(30);
        pin3 = 1'b0;
        cyc(28);
        chk1(filt_out[3], 1'b0);
        cyc(60);
        chk1(filt_out[3], 1'b0);
        // a short dip restarts the stability timer
        pin3 = 1'b1;
        cyc(30);
        pin3 = 1'b0;
        cyc(5);
        lat(1'b1, 32'd54);
        lat(1'b0, 32'd54);

        // pass-then-hold: edge after stable time goes straight through
        db_mode[7:6] = 2'b01;
        cyc(60);
        lat(1'b1, 32'd3);
        for (int i = 0; i < 4; i++) begin
            pin3 = ~pin3;
            cyc(5);
            chk1(filt_out[3], 1'b1);
        end
        cyc(60);
        lat(1'b0, 32'd3);
        // edge too soon after the last one is refused
        pin3 = 1'b1;
        cyc(5);
        chk1(filt_out[3], 1'b0);
        pin3 = 1'b0;
        cyc(60);

        // bypass: a one-cycle pulse still gets through
        db_mode[7:6] = 2'b10;
        cyc(4);
        pin3 = 1'b1;
        cyc(1);
        pin3 = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk1(filt_out[3], 1'b1);
        @(posedge mclk);
        #1;
        chk1(filt_out[3], 1'b0);
        @(negedge mclk);
        ctr_invert[3] = 1'b1;
        cyc(5);
        chk1(filt_out[3], 1'b1);
        ctr_invert[3] = 1'b0;
        cyc(5);
        chk1(filt_out[3], 1'b0);

        // one, two, four times: four turns forward, four back
        for (int m = 0; m < 3; m++) begin
            enc_mult[1:0] = 2'(m);
            acq();
            idq_enc_model_inst.move(16, 1'b1, 7);
            cyc(6);
            chk32(enc_pos[0], 32'(4 << m));
            chk1(enc_dir[0], 1'b1);
            chk32(enc_period[0], 32'd28);
            idq_enc_model_inst.move(16, 1'b0, 7);
            cyc(6);
            chk32(enc_pos[0], 32'h0000_0000);
            chk1(enc_dir[0], 1'b0);
        end

        // one edge every cycle, above 20 MHz on phase a
        enc_mult[1:0] = 2'b10;
        acq();
        idq_enc_model_inst.move(40, 1'b1, 1);
        cyc(6);
        chk32(enc_pos[0], 32'd40);

        // step below zero in both widths
        enc_wide[0] = 1'b0;
        acq();
        idq_enc_model_inst.move(1, 1'b0, 4);
        cyc(6);
        chk32(enc_pos[0], 32'h0000_FFFF);
        enc_wide[0] = 1'b1;
        acq();
        idq_enc_model_inst.move(1, 1'b0, 4);
        cyc(6);
        chk32(enc_pos[0], 32'hFFFF_FFFF);

        // index mark zeroes position and counts a turn
        index_en = 1'b1;
        acq();
        idq_enc_model_inst.move(6, 1'b1, 4);
        cyc(6);
        chk32(enc_pos[0], 32'd6);
        idq_enc_model_inst.mark(2);
        cyc(6);
        chk32(enc_pos[0], 32'h0000_0000);
        chk32(enc_revs, 32'h0000_0001);
        chk32(enc_pos[1], 32'h0000_0000);
        idq_enc_model_inst.move(3, 1'b1, 4);
        cyc(6);
        chk32(enc_pos[0], 32'd3);
        // acquisition start clears every count
        acq();
        cyc(2);
        chk32(enc_revs, 32'h0000_0000);
        chk32(enc_pos[0], 32'h0000_0000);
        // without index, channels 2 and 3 drive the second encoder
        index_en = 1'b0;
        acq();
        idq_enc_model_inst.mark(2);
        idq_enc_model_inst.mark(2);
        cyc(6);
        chk32(enc_pos[1], 32'd2);
        chk32(enc_period[1], 32'd3);
        chk1(enc_dir[1], 1'b1);
        complete_run;
    end
endmodule
`default_nettype wire
